// ### mie_data_mem.sv
// module: byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mie_data_mem
   import mie_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // memory port
   mie_mem_if.mem    port
);
   logic [DATA_W-1:0] cells [MEM_DEPTH];

   // contents are not reset: software initialises what it uses
   always_ff @(posedge core_clk) begin
      if (port.we) begin
         cells[port.addr] <= port.wdata;
      end
   end

   // read returns the old byte when read and write meet
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port.rdata <= ZERO_BYTE;
      end else begin
         port.rdata <= cells[port.addr];
      end
   end
endmodule
`default_nettype wire

// ### mie_exec_core.sv
// module: execution of a subset of an 8-bit core's instructions, wishbone registers
`timescale 1ns/1ps
`default_nettype none
module mie_exec_core
   import mie_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_dat_w,
   output logic      [31:0] wb_dat_r,
   output logic             wb_ack,
   // instruction status
   output logic             retire
);
   // ----------------------------------------------------------------
   // functions and state
   // ----------------------------------------------------------------
   function automatic logic is_nil(input logic [DATA_W-1:0] v);
      return (v == ZERO_BYTE);
   endfunction
   function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
      return 8'h01 << b;
   endfunction
   function automatic logic writes_mem(input mie_op_t o);
      return (o == OP_ADD_M) || (o == OP_AND_M) || (o == OP_ZERO_FILL) || (o == OP_BIT_ZERO);
   endfunction

   mie_state_t           state;
   mie_op_t              op;
   logic [DATA_W-1:0]    imm, wreg, res;
   logic [ADDR_W-1:0]    maddr, bus_maddr;
   logic [2:0]           bsel;
   logic [PC_W-1:0]      pc, tgt;
   logic [FLG_W-1:0]     flags;
   logic [PC_W-1:0]      stack [STK_DEPTH];
   logic [STK_PTR_W-1:0] sp;
   logic                 bus_rd_pend, req, idle, wr_ok, start;
   logic [8:0]           sum9;
   logic [4:0]           sum5;
   mie_mem_if            mif ();

   mie_data_mem u_mem (
      .core_clk (core_clk),
      .rst      (rst),
      .port     (mif.mem)
   );

   // ----------------------------------------------------------------
   // bus decode and datapath
   // ----------------------------------------------------------------
   assign req   = wb_cyc & wb_stb & ~wb_ack;
   assign idle  = (state == ST_IDLE);
   // writes wait for idle so software never races the sequencer
   assign wr_ok = req & wb_we & idle & wb_sel[0];
   assign start = wr_ok & (wb_adr == OFS_CMD) & (wb_sel[2:0] == 3'b111);

   always_comb begin
      sum9 = {1'b0, wreg} + {1'b0, mif.rdata};
      sum5 = {1'b0, wreg[3:0]} + {1'b0, mif.rdata[3:0]};
      case (op)
         OP_ADD_M:            res = sum9[7:0];
         OP_AND_AM, OP_AND_M: res = wreg & mif.rdata;
         OP_AND_AI:           res = wreg & imm;
         OP_BIT_ZERO:         res = mif.rdata & ~bit_mask(bsel);
         default:             res = ZERO_BYTE;
      endcase
   end

   // memory port: bus owns it while idle, sequencer otherwise
   always_comb begin
      if (idle) begin
         mif.addr  = bus_maddr;
         mif.we    = wr_ok & (wb_adr == OFS_MEM_DATA);
         mif.wdata = wb_dat_w[7:0];
      end else begin
         mif.addr  = maddr;
         mif.we    = (state == ST_EXEC) & writes_mem(op);
         mif.wdata = res;
      end
   end

   // ----------------------------------------------------------------
   // command latch and sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         op    <= OP_NONE;
         imm   <= ZERO_BYTE;
         maddr <= '0;
         bsel  <= '0;
         tgt   <= PC_RST;
      end else if (start) begin
         op    <= mie_op_t'(wb_dat_w[CMD_OP_LSB +: 4]);
         imm   <= wb_dat_w[CMD_IMM_LSB +: DATA_W];
         maddr <= wb_dat_w[CMD_ADDR_LSB +: ADDR_W];
         bsel  <= wb_dat_w[CMD_BIT_LSB +: 3];
         tgt   <= wb_dat_w[CMD_TGT_LSB +: PC_W];
      end
   end

   // one instruction cycle is read then exec
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:   state <= start ? ST_READ : ST_IDLE;
            ST_READ:   state <= ST_EXEC;
            ST_EXEC:   state <= (op == OP_CALL) ? ST_CALL_A : ST_IDLE;
            ST_CALL_A: state <= ST_CALL_B;
            ST_CALL_B: state <= ST_IDLE;
            default:   state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         retire <= 1'b0;
      end else begin
         retire <= ((state == ST_EXEC) & (op != OP_CALL)) | (state == ST_CALL_B);
      end
   end

   // ----------------------------------------------------------------
   // architectural registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wreg <= WREG_RST;
      end else if (wr_ok & (wb_adr == OFS_WREG)) begin
         wreg <= wb_dat_w[7:0];
      end else if ((state == ST_EXEC) & ((op == OP_AND_AM) | (op == OP_AND_AI))) begin
         wreg <= res;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags <= FLAGS_RST;
      end else if (wr_ok & (wb_adr == OFS_FLAGS)) begin
         flags <= wb_dat_w[FLG_W-1:0];
      end else if (state == ST_EXEC) begin
         case (op)
            OP_ADD_M: begin
               flags[FLG_NIL]   <= is_nil(res);
               flags[FLG_SPILL] <= sum9[8];
               flags[FLG_HALF]  <= sum5[4];
               flags[FLG_WRAP]  <= (wreg[7] == mif.rdata[7]) & (res[7] != wreg[7]);
               flags[FLG_SCMP]  <= ((wreg[7] == mif.rdata[7]) & (res[7] != wreg[7])) ^ res[7];
            end
            OP_AND_AM, OP_AND_AI, OP_AND_M: flags[FLG_NIL] <= is_nil(res);
            default: flags <= flags;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc <= PC_RST;
      end else if (wr_ok & (wb_adr == OFS_PC)) begin
         pc <= wb_dat_w[PC_W-1:0];
      end else if ((state == ST_EXEC) & (op != OP_CALL)) begin
         pc <= pc + PC_STEP;
      end else if (state == ST_CALL_B) begin
         pc <= tgt;
      end
   end

   // stack is circular: a ninth push overwrites the oldest entry
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sp <= '0;
         for (int i = 0; i < STK_DEPTH; i++) begin
            stack[i] <= PC_RST;
         end
      end else if ((state == ST_EXEC) & (op == OP_CALL)) begin
         stack[sp] <= pc + PC_STEP;
         sp        <= sp + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_maddr <= '0;
      end else if (wr_ok & (wb_adr == OFS_MEM_ADDR)) begin
         bus_maddr <= wb_dat_w[ADDR_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // wishbone answer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_rd_pend <= 1'b0;
      end else begin
         bus_rd_pend <= req & ~wb_we & idle & (wb_adr == OFS_MEM_DATA) & ~bus_rd_pend;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_ack <= 1'b0;
      end else if (wb_ack) begin
         wb_ack <= 1'b0;
      end else if (req & wb_we) begin
         wb_ack <= idle;
      end else if (req & (wb_adr == OFS_MEM_DATA)) begin
         wb_ack <= bus_rd_pend;
      end else if (req) begin
         wb_ack <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wb_dat_r <= 32'h0000_0000;
      end else if (req & ~wb_we) begin
         case (wb_adr)
            OFS_WREG:      wb_dat_r <= 32'(wreg);
            OFS_FLAGS:     wb_dat_r <= 32'(flags);
            OFS_PC:        wb_dat_r <= 32'(pc);
            OFS_STATUS:    wb_dat_r <= 32'({sp, ~idle});
            OFS_STACK_TOP: wb_dat_r <= 32'(stack[sp - 1'b1]);
            OFS_MEM_ADDR:  wb_dat_r <= 32'(bus_maddr);
            OFS_MEM_DATA:  wb_dat_r <= 32'(mif.rdata);
            default:       wb_dat_r <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_add_writeback: assert property ((state == ST_EXEC) && (op == OP_ADD_M) |->
      mif.we && (mif.wdata == 8'(wreg + mif.rdata)) ##1 flags[FLG_SPILL] == $past(sum9[8]))
      else $error("add result or spill flag wrong");
   a_and_mem_acc: assert property ((state == ST_EXEC) && (op == OP_AND_AM) |=>
      (wreg == ($past(wreg) & $past(mif.rdata))) && (flags[4:1] == $past(flags[4:1])))
      else $error("and with memory into wreg wrong");
   a_and_imm_acc: assert property ((state == ST_EXEC) && (op == OP_AND_AI) |=>
      (wreg == ($past(wreg) & $past(imm))) && (flags[4:1] == $past(flags[4:1])))
      else $error("and with immediate into wreg wrong");
   a_and_to_mem: assert property ((state == ST_EXEC) && (op == OP_AND_M) |->
      mif.we && (mif.wdata == (wreg & mif.rdata)) ##1 $stable(wreg))
      else $error("and to memory wrong");
   a_call_push: assert property ((state == ST_EXEC) && (op == OP_CALL) |=>
      (stack[$past(sp)] == ($past(pc) + PC_STEP)) && (sp == $past(sp) + 1'b1))
      else $error("call return address not pushed");
   a_call_jump: assert property ((state == ST_CALL_B) |=>
      (pc == $past(tgt)) && (flags == $past(flags, 4)))
      else $error("call target or flags wrong");
   a_call_length: assert property (start && (wb_dat_w[CMD_OP_LSB +: 4] == OP_CALL) |=>
      (state == ST_READ) ##1 (state == ST_EXEC) ##1 (state == ST_CALL_A)
      ##1 (state == ST_CALL_B) ##1 (state == ST_IDLE) && retire)
      else $error("call did not take two instruction cycles");
   a_zero_fill: assert property ((state == ST_EXEC) && (op == OP_ZERO_FILL) |->
      mif.we && (mif.wdata == ZERO_BYTE) ##1 $stable(flags))
      else $error("zero fill wrong");
   a_clear_bit: assert property ((state == ST_EXEC) && (op == OP_BIT_ZERO) |->
      mif.we && (mif.wdata == (mif.rdata & ~bit_mask(bsel))) ##1 $stable(flags))
      else $error("clear bit wrong");
   a_nil_flag: assert property ((state == ST_EXEC) && (op inside {OP_ADD_M, OP_AND_AM,
      OP_AND_AI, OP_AND_M}) |=> flags[FLG_NIL] == ($past(res) == ZERO_BYTE))
      else $error("result-nil flag wrong");
   a_single_cycle: assert property (start && (wb_dat_w[CMD_OP_LSB +: 4] != OP_CALL) |=>
      (state == ST_READ) ##1 (state == ST_EXEC) ##1 (state == ST_IDLE) && retire)
      else $error("instruction not single cycle");
   c_add:      cover property ((state == ST_EXEC) && (op == OP_ADD_M) && sum9[8]);
   c_call:     cover property ((state == ST_CALL_B) ##1 retire);
   c_bit_zero: cover property ((state == ST_EXEC) && (op == OP_BIT_ZERO));
   c_mem_read: cover property (bus_rd_pend ##1 wb_ack);
endmodule
`default_nettype wire

// ### mie_mem_if.sv
// interface: data memory port between sequencer and memory
`timescale 1ns/1ps
`default_nettype none
interface mie_mem_if
   import mie_pkg::*;
();
   logic [ADDR_W-1:0] addr;
   logic              we;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ### mie_pkg.sv
// package: constants and types of the instruction execution block
package mie_pkg;

   // -----------------------------------------------------------------
   // widths and depths
   // -----------------------------------------------------------------
   localparam int unsigned DATA_W    = 8;
   localparam int unsigned ADDR_W    = 6;
   localparam int unsigned MEM_DEPTH = 64;
   localparam int unsigned PC_W      = 12;
   localparam int unsigned STK_DEPTH = 8;
   localparam int unsigned STK_PTR_W = 3;
   localparam int unsigned FLG_W     = 5;

   // -----------------------------------------------------------------
   // register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CMD       = 8'h00;
   localparam logic [7:0] OFS_WREG      = 8'h04;
   localparam logic [7:0] OFS_FLAGS     = 8'h08;
   localparam logic [7:0] OFS_PC        = 8'h0c;
   localparam logic [7:0] OFS_STATUS    = 8'h10;
   localparam logic [7:0] OFS_STACK_TOP = 8'h14;
   localparam logic [7:0] OFS_MEM_ADDR  = 8'h18;
   localparam logic [7:0] OFS_MEM_DATA  = 8'h1c;

   // -----------------------------------------------------------------
   // command word fields
   // -----------------------------------------------------------------
   localparam int unsigned CMD_IMM_LSB  = 0;
   localparam int unsigned CMD_TGT_LSB  = 0;
   localparam int unsigned CMD_ADDR_LSB = 8;
   localparam int unsigned CMD_BIT_LSB  = 16;
   localparam int unsigned CMD_OP_LSB   = 20;

   // -----------------------------------------------------------------
   // flag bit positions
   // -----------------------------------------------------------------
   localparam int unsigned FLG_NIL   = 0;
   localparam int unsigned FLG_SPILL = 1;
   localparam int unsigned FLG_HALF  = 2;
   localparam int unsigned FLG_WRAP  = 3;
   localparam int unsigned FLG_SCMP  = 4;

   // -----------------------------------------------------------------
   // reset values and steps
   // -----------------------------------------------------------------
   localparam logic [DATA_W-1:0]    WREG_RST  = 8'h00;
   localparam logic [FLG_W-1:0]     FLAGS_RST = 5'h00;
   localparam logic [PC_W-1:0]      PC_RST    = 12'h000;
   localparam logic [PC_W-1:0]      PC_STEP   = 12'h001;
   localparam logic [DATA_W-1:0]    ZERO_BYTE = 8'h00;

   // -----------------------------------------------------------------
   // opcodes and sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_ADD_M     = 4'h0,
      OP_AND_AM    = 4'h1,
      OP_AND_AI    = 4'h2,
      OP_AND_M     = 4'h3,
      OP_CALL      = 4'h4,
      OP_ZERO_FILL = 4'h5,
      OP_BIT_ZERO  = 4'h6,
      OP_NONE      = 4'hf
   } mie_op_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_READ   = 3'b001,
      ST_EXEC   = 3'b010,
      ST_CALL_A = 3'b011,
      ST_CALL_B = 3'b100
   } mie_state_t;

endpackage

// ### tb_top.sv
// testbench: instruction execution block exercised over its wishbone registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mie_pkg::*;
;
   // -----------------------------------------------------------------
   // stimulus table
   // -----------------------------------------------------------------
   typedef struct {
      mie_op_t    op;
      logic [5:0] adr;
      logic [7:0] imm;
      logic [7:0] wreg;
      logic [7:0] mem;
      logic [4:0] flg;
      logic [7:0] x_wreg;
      logic [7:0] x_mem;
      logic [4:0] x_flg;
   } mie_row_t;

   localparam int LIMIT = 20000;

   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        wb_cyc   = 1'b0;
   logic        wb_stb   = 1'b0;
   logic        wb_we    = 1'b0;
   logic [7:0]  wb_adr   = 8'h00;
   logic [3:0]  wb_sel   = 4'h0;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic        wb_ack;
   logic        retire;
   int          miscompares = 0;
   int          checked     = 0;
   int          cycles      = 0;
   int          retire_cnt  = 0;
   int          retire_at   = 0;
   int          last_ack    = 0;
   mie_row_t    rows[14];

   mie_exec_core dut (
      .core_clk (core_clk),
      .rst      (rst),
      .wb_cyc   (wb_cyc),
      .wb_stb   (wb_stb),
      .wb_we    (wb_we),
      .wb_adr   (wb_adr),
      .wb_sel   (wb_sel),
      .wb_dat_w (wb_dat_w),
      .wb_dat_r (wb_dat_r),
      .wb_ack   (wb_ack),
      .retire   (retire)
   );

   always #2.5 core_clk = ~core_clk;

   // retire stamps use the same cycle count as the bus task, so latency is exact
   always @(posedge core_clk) begin
      if (retire === 1'b1) begin
         retire_cnt <= retire_cnt + 1;
         retire_at  <= cycles;
      end
   end

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         conclude();
      end
   end

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one classic cycle; a trailing idle cycle keeps cyc and stb low between requests
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                       input logic [3:0] sel, output logic [31:0] rd);
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= adr;
      wb_dat_w <= dat;
      wb_sel   <= sel;
      // only the bench timeout ends a wait for the answer
      do begin
         @(posedge core_clk);
      end while (wb_ack !== 1'b1);
      rd       = wb_dat_r;
      last_ack = cycles;
      wb_cyc   <= 1'b0;
      wb_stb   <= 1'b0;
      wb_we    <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      xfer(1'b1, adr, dat, 4'hf, d);
   endtask

   task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b0, adr, 32'h0, 4'hf, d);
      check(name, d, exp);
   endtask

   task automatic launch(input logic [31:0] cmd, output int lat);
      int          c0;
      logic [31:0] d;
      c0 = retire_cnt;
      xfer(1'b1, OFS_CMD, cmd, 4'hf, d);
      while (retire_cnt == c0) begin
         @(posedge core_clk);
      end
      lat = retire_at - last_ack;
      repeat (3) @(posedge core_clk);
      check("retire pulses", 32'(retire_cnt - c0), 32'h1);
   endtask

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      int          lat;
      int          c0;
      logic [31:0] d;
      logic [11:0] pc_prev;
      logic [11:0] tgts[2];
      logic [7:0]  offs[5];
      rows = '{
         '{OP_ADD_M,     6'h01, 8'h00, 8'h7f, 8'h01, 5'h00, 8'h7f, 8'h80, 5'h0c},
         '{OP_ADD_M,     6'h3f, 8'h00, 8'hff, 8'h01, 5'h00, 8'hff, 8'h00, 5'h07},
         '{OP_ADD_M,     6'h00, 8'h00, 8'h80, 8'h80, 5'h04, 8'h80, 8'h00, 5'h1b},
         '{OP_ADD_M,     6'h0c, 8'h00, 8'h10, 8'h90, 5'h00, 8'h10, 8'ha0, 5'h10},
         '{OP_AND_AM,    6'h02, 8'h00, 8'hf0, 8'h0f, 5'h1e, 8'h00, 8'h0f, 5'h1f},
         '{OP_AND_AM,    6'h03, 8'h00, 8'h3c, 8'h2a, 5'h1f, 8'h28, 8'h2a, 5'h1e},
         '{OP_AND_AI,    6'h04, 8'h0f, 8'ha5, 8'h55, 5'h01, 8'h05, 8'h55, 5'h00},
         '{OP_AND_M,     6'h05, 8'h00, 8'hcc, 8'haa, 5'h0f, 8'hcc, 8'h88, 5'h0e},
         '{OP_AND_M,     6'h06, 8'h00, 8'h0f, 8'hf0, 5'h1e, 8'h0f, 8'h00, 5'h1f},
         '{OP_ZERO_FILL, 6'h07, 8'h00, 8'h11, 8'h5a, 5'h15, 8'h11, 8'h00, 5'h15},
         '{OP_BIT_ZERO,  6'h08, 8'h07, 8'h22, 8'hff, 5'h0a, 8'h22, 8'h7f, 5'h0a},
         '{OP_BIT_ZERO,  6'h09, 8'h00, 8'h33, 8'h01, 5'h0a, 8'h33, 8'h00, 5'h0a},
         '{OP_BIT_ZERO,  6'h0a, 8'h03, 8'h44, 8'hf7, 5'h00, 8'h44, 8'hf7, 5'h00},
         '{OP_NONE,      6'h0b, 8'h00, 8'h55, 8'h66, 5'h13, 8'h55, 8'h66, 5'h13}};
      tgts = '{12'h3a5, 12'hfff};
      offs = '{OFS_WREG, OFS_FLAGS, OFS_PC, OFS_STATUS, OFS_STACK_TOP};
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      foreach (offs[i]) rdchk("reset value", offs[i], 32'h0);
      rdchk("unmapped read", 8'h20, 32'h0);
      check("no retire after reset", 32'(retire_cnt), 32'h0);
      $display("test reset done");

      foreach (rows[i]) begin
         wr(OFS_MEM_ADDR, {26'h0, rows[i].adr});
         wr(OFS_MEM_DATA, {24'h0, rows[i].mem});
         wr(OFS_WREG, {24'h0, rows[i].wreg});
         wr(OFS_FLAGS, {27'h0, rows[i].flg});
         wr(OFS_PC, 32'h100 + 32'(i));
         launch({8'h0, rows[i].op, 1'b0, rows[i].imm[2:0], 2'b00, rows[i].adr,
                 rows[i].imm}, lat);
         check("single latency", 32'(lat), 32'h2);
         rdchk("wreg", OFS_WREG, {24'h0, rows[i].x_wreg});
         rdchk("flags", OFS_FLAGS, {27'h0, rows[i].x_flg});
         rdchk("mem byte", OFS_MEM_DATA, {24'h0, rows[i].x_mem});
         rdchk("pc step", OFS_PC, 32'h101 + 32'(i));
      end
      $display("test table done");

      // two nested calls, the first crossing a byte boundary of the return address
      wr(OFS_FLAGS, 32'h1b);
      wr(OFS_WREG, 32'h5c);
      wr(OFS_PC, 32'h0ff);
      pc_prev = 12'h0ff;
      for (int k = 0; k < 2; k++) begin
         launch({8'h0, OP_CALL, 8'h00, tgts[k]}, lat);
         check("call latency", 32'(lat), 32'h4);
         rdchk("call target", OFS_PC, {20'h0, tgts[k]});
         rdchk("return address", OFS_STACK_TOP, {20'h0, pc_prev + 12'h001});
         rdchk("stack depth", OFS_STATUS, 32'(k + 1) << 1);
         rdchk("call flags", OFS_FLAGS, 32'h1b);
         rdchk("call wreg", OFS_WREG, 32'h5c);
         pc_prev = tgts[k];
      end
      $display("test call done");

      // a command written without all its byte lanes must not run
      c0 = retire_cnt;
      xfer(1'b1, OFS_CMD, {8'h0, OP_ZERO_FILL, 20'h0}, 4'h3, d);
      repeat (6) @(posedge core_clk);
      check("partial command", 32'(retire_cnt - c0), 32'h0);
      rdchk("pc kept", OFS_PC, 32'hfff);
      $display("test partial command done");

      // while a call runs status shows busy, and a register write waits for idle
      wr(OFS_CMD, {8'h0, OP_CALL, 8'h00, 12'h010});
      rdchk("busy status", OFS_STATUS, 32'h7);
      wr(OFS_CMD, {8'h0, OP_CALL, 8'h00, 12'h020});
      wr(OFS_WREG, 32'h3c);
      check("write after retire", 32'(last_ack - retire_at), 32'h1);
      rdchk("stalled write", OFS_WREG, 32'h3c);
      rdchk("pc after calls", OFS_PC, 32'h020);
      $display("test busy done");

      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      foreach (offs[i]) rdchk("second reset", offs[i], 32'h0);
      $display("test second reset done");
      conclude();
   end
endmodule
`default_nettype wire
